// >>> core/pcicap_regs.v
// pcicap_regs.v: read-only express capability header and device
// capability words behind an apb slave.
// assumes synchronous inputs on sys_clk; straps settle before use.
//
// Operation
// - capability id byte always reads 10h.
// - bits 15:8 of header point to vital product data at D8h.
// - port type encodings 0,1,4,5,6,7,8; others reserved.
// - port type reads 7h forward, 8h reverse.
// - slot implemented bit 24 reads 0 forward, 1 reverse.
// - phantom function field bits 4:3 reads zero.
// - bit 5 reads 1, eight-bit tags supported.
// - l0s acceptable latency bits 8:6 reads 000.
// - l1 acceptable latency bits 11:9 reads 000.
// - attention button bit 12 is 1 only with hot-plug in forward.
// - indicator bits 13, 14 are 1 with hot-plug in forward.
// - slot power value bits 25:18 reset 00h, loaded per message.
// - slot power scale bits 27:26 reset 00, loaded per message.
//
// The implementer's own choice: the APB register port.
`include "pcicap_consts.vh"

module pcicap_regs (
    input wire sys_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire reverse_mode,
    input wire hotplug_strap,
    input wire spl_msg_valid,
    input wire [7:0] spl_msg_value,
    input wire [1:0] spl_msg_scale
);

    // state of the apb answer machine
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg mode_rev_reg;
    reg hp_strap_reg;
    reg strap_taken_reg;
    reg [31:0] rdata_next;
    reg err_next;
    wire [7:0] spl_value;
    wire [1:0] spl_scale;
    wire hp_fwd;
    wire [31:0] hdr_word;
    wire [31:0] dev_word;
    wire [31:0] strap_word;
    wire [31:0] msg_word;

    pcicap_slot_power u_spl (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .msg_valid(spl_msg_valid),
        .msg_value(spl_msg_value),
        .msg_scale(spl_msg_scale),
        .spl_value_reg(spl_value),
        .spl_scale_reg(spl_scale)
    );

    // port type chosen by direction; only the two bridge codes occur
    function [3:0] port_type;
        input rev;
        begin
            if (rev) begin
                port_type = `PCICAP_PT_REV;
            end else begin
                port_type = `PCICAP_PT_FWD;
            end
        end
    endfunction

    // matches an aligned word address, low two bits ignored
    function addr_hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            addr_hit = (a[11:2] == ofs[11:2]);
        end
    endfunction

    // straps are caught once after reset release, never under reset,
    // so a glitch on the pins later cannot flip what software sees
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_rev_reg <= 1'b0;
            hp_strap_reg <= 1'b0;
            strap_taken_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            mode_rev_reg <= reverse_mode;
            hp_strap_reg <= hotplug_strap;
            strap_taken_reg <= 1'b1;
        end
    end

    // hot-plug features exist only on the forward side
    assign hp_fwd = hp_strap_reg & ~mode_rev_reg;

    // header word: id, next link, version, type, slot, msg number
    assign hdr_word = {2'b00,
                       `PCICAP_IMN_VAL,
                       mode_rev_reg,
                       port_type(mode_rev_reg),
                       `PCICAP_VER_VAL,
                       `PCICAP_NEXT_VAL,
                       `PCICAP_ID_VAL};

    // device capability word assembled from fixed and live fields
    assign dev_word = {4'h0,
                       spl_scale,
                       spl_value,
                       3'b000,
                       hp_fwd, // power indicator
                       hp_fwd, // attention indicator
                       hp_fwd,
                       `PCICAP_L1_VAL,
                       `PCICAP_L0S_VAL,
                       1'b1,
                       `PCICAP_PHANTOM_VAL,
                       `PCICAP_PAYLOAD_VAL};

    // status words so software can see the latched straps and fields
    assign strap_word = {29'h00000000, strap_taken_reg, hp_strap_reg,
                         mode_rev_reg};
    assign msg_word = {22'h000000, spl_scale, spl_value};

    // read mux; unmapped addresses answer with an error and zero data
    always @* begin
        rdata_next = 32'h00000000;
        err_next = 1'b0;
        if (addr_hit(paddr, `PCICAP_OFS_HDR)) begin
            rdata_next = hdr_word;
        end else if (addr_hit(paddr, `PCICAP_OFS_DEV)) begin
            rdata_next = dev_word;
        end else if (addr_hit(paddr, `PCICAP_OFS_STRAP)) begin
            rdata_next = strap_word;
        end else if (addr_hit(paddr, `PCICAP_OFS_MSG)) begin
            rdata_next = msg_word;
        end else begin
            err_next = 1'b1;
        end
    end

    // answer machine: one wait state, ready in the second access cycle;
    // writes are accepted but change nothing, pwdata is never stored
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (psel && penable) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // registered bus outputs keep every output straight from a flop
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && psel && penable) begin
                pready <= 1'b1;
                pslverr <= err_next;
                if (pwrite) begin
                    prdata <= 32'h00000000;
                end else begin
                    prdata <= rdata_next;
                end
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

endmodule

// >>> core/pcicap_consts.vh
// pcicap_consts.vh: offsets, field positions and fixed values of the
// express capability words. assumes plain verilog-2005 includers.
`ifndef PCICAP_CONSTS_VH
`define PCICAP_CONSTS_VH

// register byte addresses on the apb bus
`define PCICAP_OFS_HDR 12'h0B0
`define PCICAP_OFS_DEV 12'h0B4
`define PCICAP_OFS_STRAP 12'h0C0
`define PCICAP_OFS_MSG 12'h0C4

// header word fields
`define PCICAP_ID_VAL 8'h10
`define PCICAP_NEXT_VAL 8'hD8
`define PCICAP_VER_VAL 4'h1
`define PCICAP_PT_ENDPOINT 4'h0
`define PCICAP_PT_LEGACY 4'h1
`define PCICAP_PT_ROOT 4'h4
`define PCICAP_PT_SW_UP 4'h5
`define PCICAP_PT_SW_DOWN 4'h6
`define PCICAP_PT_FWD 4'h7
`define PCICAP_PT_REV 4'h8
`define PCICAP_IMN_VAL 5'h00

// device capability word fields
`define PCICAP_PAYLOAD_VAL 3'h1
`define PCICAP_PHANTOM_VAL 2'h0
`define PCICAP_L0S_VAL 3'h0
`define PCICAP_L1_VAL 3'h0
`define PCICAP_SPL_VAL_RST 8'h00
`define PCICAP_SPL_SCL_RST 2'h0

`endif

// >>> core/pcicap_slot_power.v
// pcicap_slot_power.v: holder of the captured slot power limit.
// assumes msg_valid is a one-cycle pulse per received limit message.
`include "pcicap_consts.vh"

module pcicap_slot_power (
    input wire sys_clk,
    input wire rst_n,
    input wire msg_valid,
    input wire [7:0] msg_value,
    input wire [1:0] msg_scale,
    output reg [7:0] spl_value_reg,
    output reg [1:0] spl_scale_reg
);

    // each message overwrites both fields together
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            spl_value_reg <= `PCICAP_SPL_VAL_RST;
            spl_scale_reg <= `PCICAP_SPL_SCL_RST;
        end else if (msg_valid) begin
            spl_value_reg <= msg_value;
            spl_scale_reg <= msg_scale;
        end
    end

endmodule

// >>> testbench/pcicap_regs_chk.sv
// pcicap_regs_chk.sv: assertions on the capability words read over apb.
// assumes straps count as caught at the first edge after reset release.
module pcicap_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire reverse_mode,
    input wire hotplug_strap,
    input wire spl_msg_valid,
    input wire [7:0] spl_msg_value,
    input wire [1:0] spl_msg_scale
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [9:0] spl_reg;
    logic rev_q, hp_q, taken_q;
    wire rd_ok = pready && !pwrite && !pslverr;
    wire rd_hdr = rd_ok && paddr[11:2] == 10'h02C;
    wire rd_dev = rd_ok && paddr[11:2] == 10'h02D;
    wire hp_fwd = hp_q && !rev_q;
    // straps judged as caught once after release, so later pin moves
    // on the straps must not show in what software reads
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) {taken_q, hp_q, rev_q} <= 3'h0;
        else if (!taken_q) {taken_q, hp_q, rev_q} <=
            {1'b1, hotplug_strap, reverse_mode};
    end
    // shadow of the captured limit, cleared by reset as the device is
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) spl_reg <= 10'h000;
        else if (spl_msg_valid) spl_reg <= {spl_msg_scale, spl_msg_value};
    end
    a_id_next: assert property (rd_hdr |->
        prdata[15:0] == 16'hD810)
        else $error("header id or next link wrong");
    a_port_type: assert property (rd_hdr |->
        prdata[23:20] == (rev_q ? 4'h8 : 4'h7))
        else $error("port type wrong");
    a_slot_bit: assert property (rd_hdr |-> prdata[24] == rev_q)
        else $error("slot bit wrong");
    a_hdr_zero: assert property (rd_hdr |-> prdata[31:25] == 7'h00)
        else $error("header upper bits not zero");
    a_dev_fixed: assert property (rd_dev |->
        prdata[11:0] == 12'h021)
        else $error("fixed device fields wrong");
    a_hotplug_bits: assert property (rd_dev |->
        prdata[14:12] == {3{hp_fwd}})
        else $error("hot-plug bits wrong");
    a_dev_reserved: assert property (rd_dev |->
        prdata[31:28] == 4'h0 && prdata[17:15] == 3'h0)
        else $error("device reserved bits not zero");
    a_spl_capture: assert property (rd_dev |->
        prdata[27:18] == spl_reg)
        else $error("slot power limit wrong");
    cover property (rd_hdr && rev_q);
    cover property (rd_dev && hp_fwd);
    cover property (pready && pslverr);
endmodule

bind pcicap_regs pcicap_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reverse_mode(reverse_mode),
    .hotplug_strap(hotplug_strap), .spl_msg_valid(spl_msg_valid),
    .spl_msg_value(spl_msg_value), .spl_msg_scale(spl_msg_scale));

// >>> testbench/tb.sv
// tb.sv: reads the capability words for every strap setting.
// assumes the apb slave answers within 20 cycles of its setup.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, reverse_mode = 1'b0, hotplug_strap = 1'b0;
    logic spl_msg_valid = 1'b0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [7:0] spl_msg_value = 8'h00;
    logic [1:0] spl_msg_scale = 2'h0;
    logic [65:0] rows [0:3];
    int n_errors = 0, samples_checked = 0;
    pcicap_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reverse_mode(reverse_mode), .hotplug_strap(hotplug_strap),
        .spl_msg_valid(spl_msg_valid), .spl_msg_value(spl_msg_value),
        .spl_msg_scale(spl_msg_scale));
    always #50 sys_clk = ~sys_clk;
    task automatic tally_and_finish;
        $display("checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // a used-up wait counts as a mismatch and ends the run at once
        if (i == 20) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    // straps must be steady before release, they are latched once
    task automatic restart(input logic rev, input logic hp);
        reverse_mode <= rev;
        hotplug_strap <= hp;
        rst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
    initial begin
        rows[0] = {2'b00, 32'h0071D810, 32'h00000021};
        rows[1] = {2'b01, 32'h0071D810, 32'h00007021};
        rows[2] = {2'b10, 32'h0181D810, 32'h00000021};
        rows[3] = {2'b11, 32'h0181D810, 32'h00000021};
        for (int k = 0; k < 4; k++) begin
            restart(rows[k][65], rows[k][64]);
            apb(1'b0, 12'h0B0, 32'h0);
            chk(rd, rows[k][63:32]);
            chk({31'h0, er}, 32'h00000000);
            apb(1'b0, 12'h0B4, 32'h0);
            chk(rd, rows[k][31:0]);
            chk({29'h0, rd[14:12]}, {29'h0, rows[k][14:12]});
            chk({22'h0, rd[27:18]}, 32'h00000000);
            $display("strap row %0d done", k);
        end
        @(posedge sys_clk);
        spl_msg_valid <= 1'b1;
        spl_msg_value <= 8'hA5;
        spl_msg_scale <= 2'h3;
        @(posedge sys_clk);
        spl_msg_valid <= 1'b0;
        apb(1'b0, 12'h0B4, 32'h0);
        chk(rd, 32'h0E940021);
        apb(1'b0, 12'h0C4, 32'h0);
        chk(rd, 32'h000003A5);
        apb(1'b0, 12'h0C0, 32'h0);
        chk(rd, 32'h00000007);
        apb(1'b1, 12'h0B4, 32'hFFFFFFFF);
        apb(1'b0, 12'h0B4, 32'h0);
        chk(rd, 32'h0E940021);
        apb(1'b1, 12'h0B0, 32'hFFFFFFFF);
        apb(1'b0, 12'h0B0, 32'h0);
        chk(rd, 32'h0181D810);
        // straps moved after the catch must not show in either word
        @(posedge sys_clk);
        reverse_mode <= 1'b0;
        hotplug_strap <= 1'b1;
        apb(1'b0, 12'h0B0, 32'h0);
        chk(rd, 32'h0181D810);
        apb(1'b0, 12'h0B4, 32'h0);
        chk({29'h0, rd[14:12]}, 32'h00000000);
        apb(1'b0, 12'h0D0, 32'h0);
        chk({31'h0, er}, 32'h00000001);
        chk(rd, 32'h00000000);
        $display("message and write test done");
        restart(1'b0, 1'b0);
        apb(1'b0, 12'h0B4, 32'h0);
        chk(rd, 32'h00000021);
        $display("second reset test done");
        tally_and_finish();
    end
endmodule
